// file: logic/dslm_pkg.sv
// Purpose: Shared constants and carriers for the drive status and life monitor words.
// Assumes: 50 MHz system clock, synchronous active-low reset.
// Notes: Both monitor words are read-only and refreshed every clock.
// Behaviour
// [R1] Flag bits read 1 on, 0 off
// [R2] Status bit 5 follows stall-prevention overload
// [R3] Bit 6 set at frequency threshold, reverse separate
// [R4] Bit 7 set when protection trips output
// [R5] Bit 9 set on internal safety-circuit fault
// [R6] Bit 12: current above level beyond persistence
// [R7] Bit 13: current near zero beyond persistence
// [R8] Bits 10,11,14: edit, network command, ready
// [R9] Unused bits always read zero
// [R10] Life word bits 0-7 hold fault code
// [R11] Bit 8: control capacitor life below 10%
// [R12] Bit 9: main capacitor below 85% measured
// [R13] Operator starts measurement; completion reads 3
// [R14] Bit 10: fan speed at or below 50%
// [R15] Inrush closures lower life; alarm at 900000
// [R16] Life alarms clear after part replacement
// [R17] Bit 12: heatsink near 85% overheat temperature
// [R18] Bit 13 shows alarm display state
// [R19] Bit 15: maintenance timer reaches alarm time
// [R20] Alarm time 9999 disables maintenance alarm
package dslm_pkg;

    // ----------------------------------------------------------------
    // Status word bit positions
    // ----------------------------------------------------------------
    localparam int ST_OVERLOAD = 5;
    localparam int ST_FREQ_DET = 6;
    localparam int ST_FAULT = 7;
    localparam int ST_SAFETY = 9;
    localparam int ST_EDIT = 10;
    localparam int ST_NETCMD = 11;
    localparam int ST_CUR_DET = 12;
    localparam int ST_ZERO_CUR = 13;
    localparam int ST_READY = 14;

    // ----------------------------------------------------------------
    // Fault and life word bit positions
    // ----------------------------------------------------------------
    localparam int LF_CODE_LSB = 0;
    localparam int LF_CTRL_CAP = 8;
    localparam int LF_MAIN_CAP = 9;
    localparam int LF_FAN = 10;
    localparam int LF_INRUSH = 11;
    localparam int LF_HEATSINK = 12;
    localparam int LF_ALARM_DISP = 13;
    localparam int LF_MAINT = 15;

    // ----------------------------------------------------------------
    // Thresholds and counts
    // ----------------------------------------------------------------
    localparam logic [6:0] LIFE_FULL_PCT = 7'h64;        // 100 %
    localparam logic [6:0] CTRL_CAP_ALARM_PCT = 7'h0a;   // 10 %
    localparam logic [6:0] MAIN_CAP_ALARM_PCT = 7'h55;   // 85 %
    localparam logic [6:0] FAN_ALARM_PCT = 7'h32;        // 50 %
    localparam logic [6:0] HEATSINK_ALARM_PCT = 7'h55;   // 85 %
    localparam logic [6:0] INRUSH_ALARM_PCT = 7'h0a;     // 10 %
    localparam logic [13:0] INRUSH_STEP_CLOSURES = 14'h2710; // 10000 per 1 %
    localparam logic [15:0] MAINT_DISABLE = 16'h270f;    // 9999
    localparam logic [1:0] CAP_MEAS_START = 2'h1;
    localparam logic [1:0] CAP_MEAS_DONE = 2'h3;
    localparam logic [15:0] PERSIST_DEFAULT = 16'h0032;  // cycles

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic overload;
        logic stall_active;
        logic reverse;
        logic [15:0] out_freq;
        logic [15:0] fwd_thresh;
        logic [15:0] rev_thresh;
        logic tripped;
        logic safety_fault;
        logic edit_enabled;
        logic net_command;
        logic [7:0] fault_code;
        logic alarm_display;
    } dslm_drive_t;

    typedef struct packed {
        logic [6:0] ctrl_cap_pct;
        logic cap_measure_valid;
        logic [6:0] main_cap_pct;
        logic [6:0] fan_speed_pct;
        logic [6:0] heatsink_pct;
        logic inrush_closure;
        logic ctrl_cap_replaced;
        logic main_cap_replaced;
        logic fan_replaced;
        logic inrush_replaced;
        logic [15:0] maint_hours;
        logic [15:0] maint_alarm_time;
    } dslm_life_t;

    function automatic logic pct_below(input logic [6:0] v, input logic [6:0] lim);
        return v < lim;
    endfunction

endpackage

// file: logic/dslm_persist.sv
// Purpose: Sets a flag once a condition has held longer than a set time.
// Assumes: Condition comes from same-clock logic.
// Notes: Flag falls as soon as the condition drops.
`timescale 1ns/10ps
`default_nettype none
module dslm_persist (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic cond_i,
    input wire logic [15:0] persist_i,
    output logic flag_o
);
    typedef struct packed {
        logic [15:0] cnt;
        logic flag;
    } dslm_pers_st_t;

    dslm_pers_st_t st_q;
    dslm_pers_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (!cond_i) begin
            st_d.cnt = 16'h0000;
            st_d.flag = 1'b0;
        end else if (st_q.cnt >= persist_i) begin
            st_d.flag = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flag_o = st_q.flag;
endmodule // dslm_persist
`default_nettype wire

// file: logic/dslm_inrush_life.sv
// Purpose: Counts inrush contact closures and derives remaining life.
// Assumes: One closure pulse per contact ON.
// Notes: Life steps down 1 % every 10000 closures, floor at 0 %.
`timescale 1ns/10ps
`default_nettype none
module dslm_inrush_life (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic closure_i,
    input wire logic replaced_i,
    output logic [6:0] life_pct_o
);
    typedef struct packed {
        logic [13:0] sub;
        logic [6:0] pct;
    } dslm_inr_st_t;

    dslm_inr_st_t st_q;
    dslm_inr_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (replaced_i) begin
            st_d.sub = 14'h0000;
            st_d.pct = dslm_pkg::LIFE_FULL_PCT; // [R16]
        end else if (closure_i) begin
            if (st_q.sub == dslm_pkg::INRUSH_STEP_CLOSURES - 14'h0001) begin
                st_d.sub = 14'h0000;
                if (st_q.pct != 7'h00) begin
                    st_d.pct = st_q.pct - 7'h01; // [R15]
                end
            end else begin
                st_d.sub = st_q.sub + 14'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_q.sub <= 14'h0000;
            st_q.pct <= dslm_pkg::LIFE_FULL_PCT;
        end else begin
            st_q <= st_d;
        end
    end

    assign life_pct_o = st_q.pct;
endmodule // dslm_inrush_life
`default_nettype wire

// file: logic/dslm_top.sv
// Purpose: Builds the drive status word and the fault and life word.
// Assumes: All inputs come from same-clock control logic.
// Notes: Words update one clock after their sources, two for the current, capacitor, fan, inrush and ready bits.
`timescale 1ns/10ps
`default_nettype none
module dslm_top (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire dslm_pkg::dslm_drive_t drive_i,
    input wire dslm_pkg::dslm_life_t life_i,
    input wire logic cur_above_i,
    input wire logic cur_zero_i,
    input wire logic [15:0] cur_persist_i,
    input wire logic [15:0] zero_persist_i,
    output logic [15:0] drive_status_word_o,
    output logic [15:0] fault_and_life_word_o
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] status;
        logic [15:0] life;
        logic main_cap_alarm;
        logic ctrl_cap_alarm;
        logic fan_alarm;
        logic ready;
    } dslm_top_st_t;

    dslm_top_st_t st_q;
    dslm_top_st_t st_d;

    logic cur_det;
    logic zero_det;
    logic [6:0] inrush_pct;
    logic [15:0] thresh;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    dslm_persist u_cur_det (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .cond_i(cur_above_i),
        .persist_i(cur_persist_i),
        .flag_o(cur_det)
    ); // [R6]

    dslm_persist u_zero_det (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .cond_i(cur_zero_i),
        .persist_i(zero_persist_i),
        .flag_o(zero_det)
    ); // [R7]

    dslm_inrush_life u_inrush (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .closure_i(life_i.inrush_closure),
        .replaced_i(life_i.inrush_replaced),
        .life_pct_o(inrush_pct)
    );

    // ----------------------------------------------------------------
    // Word composition
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.ready = 1'b1; // [R8]
        // Threshold depends on rotation direction
        thresh = drive_i.reverse ? drive_i.rev_thresh : drive_i.fwd_thresh; // [R3]

        // Control capacitor: sticky until replacement, a live alarm beats the clear
        if (dslm_pkg::pct_below(life_i.ctrl_cap_pct, dslm_pkg::CTRL_CAP_ALARM_PCT)) begin
            st_d.ctrl_cap_alarm = 1'b1; // [R11]
        end else if (life_i.ctrl_cap_replaced) begin
            st_d.ctrl_cap_alarm = 1'b0; // [R16]
        end
        // Main capacitor: judged at each completed measurement, which beats the clear
        if (life_i.cap_measure_valid) begin
            st_d.main_cap_alarm = dslm_pkg::pct_below(life_i.main_cap_pct,
                dslm_pkg::MAIN_CAP_ALARM_PCT); // [R12]
        end else if (life_i.main_cap_replaced) begin
            st_d.main_cap_alarm = 1'b0; // [R16]
        end
        // Fan: sticky until replacement, a live alarm beats the clear
        if (life_i.fan_speed_pct <= dslm_pkg::FAN_ALARM_PCT) begin
            st_d.fan_alarm = 1'b1; // [R14]
        end else if (life_i.fan_replaced) begin
            st_d.fan_alarm = 1'b0; // [R16]
        end

        st_d.status = 16'h0000; // [R9]
        st_d.status[dslm_pkg::ST_OVERLOAD] = drive_i.stall_active; // [R2]
        st_d.status[dslm_pkg::ST_FREQ_DET] = drive_i.out_freq >= thresh; // [R3]
        st_d.status[dslm_pkg::ST_FAULT] = drive_i.tripped; // [R4]
        st_d.status[dslm_pkg::ST_SAFETY] = drive_i.safety_fault; // [R5]
        st_d.status[dslm_pkg::ST_EDIT] = drive_i.edit_enabled; // [R8]
        st_d.status[dslm_pkg::ST_NETCMD] = drive_i.net_command; // [R8]
        st_d.status[dslm_pkg::ST_CUR_DET] = cur_det; // [R6]
        st_d.status[dslm_pkg::ST_ZERO_CUR] = zero_det; // [R7]
        st_d.status[dslm_pkg::ST_READY] = st_q.ready; // [R8]

        st_d.life = 16'h0000; // [R9]
        st_d.life[dslm_pkg::LF_CODE_LSB +: 8] = drive_i.fault_code; // [R10]
        st_d.life[dslm_pkg::LF_CTRL_CAP] = st_q.ctrl_cap_alarm; // [R11]
        st_d.life[dslm_pkg::LF_MAIN_CAP] = st_q.main_cap_alarm; // [R12]
        st_d.life[dslm_pkg::LF_FAN] = st_q.fan_alarm; // [R14]
        st_d.life[dslm_pkg::LF_INRUSH] = inrush_pct <= dslm_pkg::INRUSH_ALARM_PCT; // [R15]
        st_d.life[dslm_pkg::LF_HEATSINK] = life_i.heatsink_pct >= dslm_pkg::HEATSINK_ALARM_PCT; // [R17]
        st_d.life[dslm_pkg::LF_ALARM_DISP] = drive_i.alarm_display; // [R18]
        st_d.life[dslm_pkg::LF_MAINT] = (life_i.maint_alarm_time != dslm_pkg::MAINT_DISABLE) &&
            (life_i.maint_hours >= life_i.maint_alarm_time); // [R19] [R20]
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d; // [R1]
        end
    end

    assign drive_status_word_o = st_q.status;
    assign fault_and_life_word_o = st_q.life;
endmodule // dslm_top
`default_nettype wire

// file: bench/dslm_monitor.sv
// Purpose: Port checks on the two monitor words.
// Assumes: Checked flag bits lag their sources by one clock, the current flags by two.
// Notes: Bound to dslm_top from tb_top.
`timescale 1ns/10ps
`default_nettype none
module dslm_monitor (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire dslm_pkg::dslm_drive_t drive_i,
    input wire dslm_pkg::dslm_life_t life_i,
    input wire logic cur_above_i,
    input wire logic cur_zero_i,
    input wire logic [15:0] cur_persist_i,
    input wire logic [15:0] zero_persist_i,
    input wire logic [15:0] drive_status_word_o,
    input wire logic [15:0] fault_and_life_word_o
);
    wire dslm_pkg::dslm_drive_t d = drive_i;
    wire dslm_pkg::dslm_life_t l = life_i;
    wire logic [15:0] s = drive_status_word_o;
    wire logic [15:0] f = fault_and_life_word_o;
    logic [1:0] up_q;
    wire logic ok = up_q == 2'h3;
    // Edges since reset release, saturating
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    a_trip_flag: assert property (ok |-> s[7] == $past(d.tripped))
        else $error("fault flag wrong");
    a_overload_flag: assert property (ok |-> s[5] == $past(d.stall_active))
        else $error("overload flag wrong");
    a_freq_detect: assert property (ok |-> s[6] ==
        $past(d.reverse ? d.out_freq >= d.rev_thresh : d.out_freq >= d.fwd_thresh))
        else $error("frequency flag wrong");
    a_plain_flags: assert property (ok |->
        s[11:9] == $past({d.net_command, d.edit_enabled, d.safety_fault}))
        else $error("status flags wrong");
    a_code_display: assert property (ok |-> {f[13], f[7:0]} == $past({d.alarm_display, d.fault_code}))
        else $error("fault code wrong");
    a_unused_zero: assert property (!(s[8] | s[15] | f[14]))
        else $error("unused bit set");
    a_ready_bit: assert property (ok |-> s[14])
        else $error("ready bit low");
    a_reset_clear: assert property (disable iff (1'b0) !rst_n_i |=> s == 16'h0000 && f == 16'h0000)
        else $error("words not cleared");
    a_heat_prealarm: assert property (ok |-> f[12] == $past(l.heatsink_pct >= dslm_pkg::HEATSINK_ALARM_PCT))
        else $error("heatsink flag wrong");
    a_maint_due: assert property (ok |-> f[15] ==
        $past(l.maint_hours >= l.maint_alarm_time && l.maint_alarm_time != dslm_pkg::MAINT_DISABLE))
        else $error("maintenance flag wrong");
    a_cur_drop: assert property (!cur_above_i [*3] |-> !s[12])
        else $error("current flag stuck");
    a_zero_drop: assert property (!cur_zero_i [*3] |-> !s[13])
        else $error("zero current flag stuck");
endmodule // dslm_monitor
`default_nettype wire

// file: bench/dslm_master_model.sv
// Purpose: Network master copy of the cyclic input words.
// Assumes: Master refreshes its input area every clock.
// Notes: Adds one clock of delay.
`timescale 1ns/10ps
`default_nettype none
module dslm_master_model (
    input wire logic sys_clk_i,
    input wire logic [15:0] status_word_i,
    input wire logic [15:0] life_word_i,
    output logic [15:0] status_rd_o,
    output logic [15:0] life_rd_o
);
    always_ff @(posedge sys_clk_i) begin
        status_rd_o <= status_word_i;
        life_rd_o <= life_word_i;
    end
endmodule // dslm_master_model
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: Self-checking bench for the monitor words.
// Assumes: Reads go through the master model.
// Notes: Inrush count too long to reach its alarm here.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    dslm_pkg::dslm_drive_t dr = '0;
    dslm_pkg::dslm_life_t li = '0;
    logic ca = 1'b0;
    logic cz = 1'b0;
    logic [15:0] sw;
    logic [15:0] lw;
    logic [15:0] sr;
    logic [15:0] lr;
    int n_mismatch = 0;
    int check_count = 0;
    int pos[5] = '{11, 10, 9, 7, 5};
    logic [15:0] fq[4] = '{16'h05dc, 16'h05dc, 16'h03e7, 16'h07d0};
    dslm_top dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .drive_i(dr), .life_i(li), .cur_above_i(ca),
        .cur_zero_i(cz), .cur_persist_i(16'h0004), .zero_persist_i(16'h0004),
        .drive_status_word_o(sw), .fault_and_life_word_o(lw));
    dslm_master_model mst_u (.sys_clk_i(sys_clk_i), .status_word_i(sw), .life_word_i(lw),
        .status_rd_o(sr), .life_rd_o(lr));
    initial begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    task automatic chk(input logic w, input logic [15:0] m, input logic [15:0] e);
        logic [15:0] v;
        repeat (4) @(posedge sys_clk_i);
        #1;
        v = (w ? lr : sr) & m;
        check_count++;
        if (v !== e) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, v, e);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        print_verdict();
    end
    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial begin
        dr.fwd_thresh <= 16'h03e8;
        dr.rev_thresh <= 16'h07d0;
        li.ctrl_cap_pct <= 7'h64;
        li.main_cap_pct <= 7'h64;
        li.fan_speed_pct <= 7'h64;
        li.maint_alarm_time <= 16'h270f;
        repeat (6) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        chk(0, 16'hffff, 16'h4000);
        chk(1, 16'hffff, 16'h0000);
        $display("test 1 done");
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk_i);
            {dr.stall_active, dr.tripped, dr.safety_fault, dr.edit_enabled, dr.net_command} <= 5'h01 << i;
            chk(0, 16'hffff, 16'h4000 | (16'h0001 << pos[i]));
        end
        @(posedge sys_clk_i);
        dr.stall_active <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk_i);
            dr.reverse <= i[0];
            dr.out_freq <= fq[i];
            chk(0, 16'h0040, (i % 3 == 0) ? 16'h0040 : 16'h0000);
        end
        @(posedge sys_clk_i);
        dr.fault_code <= 8'ha5;
        dr.alarm_display <= 1'b1;
        chk(1, 16'h20ff, 16'h20a5);
        $display("test 2 done");
        for (int j = 0; j < 2; j++) begin
            @(posedge sys_clk_i);
            {cz, ca} <= 2'h1 << j;
            chk(0, 16'h1000 << j, 16'h0000);
            chk(0, 16'h1000 << j, 16'h1000 << j);
            @(posedge sys_clk_i);
            {cz, ca} <= 2'h0;
            chk(0, 16'h1000 << j, 16'h0000);
        end
        $display("test 3 done");
        @(posedge sys_clk_i);
        li.ctrl_cap_pct <= 7'h0a;
        li.fan_speed_pct <= 7'h33;
        li.heatsink_pct <= 7'h54;
        chk(1, 16'h1d00, 16'h0000);
        @(posedge sys_clk_i);
        li.ctrl_cap_pct <= 7'h09;
        li.fan_speed_pct <= 7'h32;
        li.heatsink_pct <= 7'h55;
        chk(1, 16'h1d00, 16'h1500);
        @(posedge sys_clk_i);
        li.ctrl_cap_pct <= 7'h64;
        li.fan_speed_pct <= 7'h64;
        li.heatsink_pct <= 7'h00;
        chk(1, 16'h1d00, 16'h0500);
        @(posedge sys_clk_i);
        li.ctrl_cap_replaced <= 1'b1;
        li.fan_replaced <= 1'b1;
        @(posedge sys_clk_i);
        li.ctrl_cap_replaced <= 1'b0;
        li.fan_replaced <= 1'b0;
        chk(1, 16'h1d00, 16'h0000);
        @(posedge sys_clk_i);
        li.main_cap_pct <= 7'h54;
        chk(1, 16'h0200, 16'h0000);
        @(posedge sys_clk_i);
        li.cap_measure_valid <= 1'b1;
        @(posedge sys_clk_i);
        li.cap_measure_valid <= 1'b0;
        chk(1, 16'h0200, 16'h0200);
        @(posedge sys_clk_i);
        li.main_cap_pct <= 7'h55;
        li.cap_measure_valid <= 1'b1;
        @(posedge sys_clk_i);
        li.cap_measure_valid <= 1'b0;
        chk(1, 16'h0200, 16'h0000);
        $display("test 4 done");
        @(posedge sys_clk_i);
        li.maint_alarm_time <= 16'h000a;
        li.maint_hours <= 16'h0009;
        chk(1, 16'h8800, 16'h0000);
        @(posedge sys_clk_i);
        li.maint_hours <= 16'h000a;
        chk(1, 16'h8800, 16'h8000);
        @(posedge sys_clk_i);
        li.maint_alarm_time <= 16'h270f;
        li.maint_hours <= 16'hffff;
        chk(1, 16'h8800, 16'h0000);
        @(posedge sys_clk_i);
        dr.tripped <= 1'b1;
        rst_n_i <= 1'b0;
        chk(0, 16'hffff, 16'h0000);
        @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        chk(0, 16'h4080, 16'h4080);
        $display("test 5 done");
        print_verdict();
    end
endmodule // tb_top
bind dslm_top dslm_monitor mon_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .drive_i(drive_i),
    .life_i(life_i), .cur_above_i(cur_above_i), .cur_zero_i(cur_zero_i), .cur_persist_i(cur_persist_i),
    .zero_persist_i(zero_persist_i), .drive_status_word_o(drive_status_word_o),
    .fault_and_life_word_o(fault_and_life_word_o));
`default_nettype wire
